/* rot_unit.sv */
/*
 * rotate-through-carry execution unit: decodes the two rotate opcodes,
 * reads the operand, rotates it, writes accumulator or register file.
 * assumes the decoder presents one instruction per four-phase cycle and
 * the register file returns read data in the read phase.
 */
// How it works
// - opcode 00 1101 with dest bit and 7-bit address rotates left via carry.
// - opcode 00 1100 with dest bit and address rotates right via carry.
// - dest bit zero writes result to accumulator, register untouched.
// - dest bit one writes result back to the addressed register.
// - only the carry flag changes; other status flags are kept.
// - one word, one cycle: decode, read, rotate, write phases.
`timescale 1ns/1ps
`default_nettype none
module rot_unit #(
    parameter int DW = rot_pkg::DATA_W
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [rot_pkg::INSN_W-1:0] I_INSN,
    input wire logic I_INSN_VALID,
    input wire logic [DW-1:0] I_RF_RDATA,
    output logic [rot_pkg::ADDR_W-1:0] O_RF_ADDR,
    output logic O_RF_RD,
    output logic O_RF_WE,
    output logic [DW-1:0] O_RF_WDATA,
    output logic [DW-1:0] O_ACC,
    output logic O_CARRY,
    output logic O_BUSY
);
    import rot_pkg::*;
    if (DW != DATA_W) begin : g_bad_width
        $error("rot_unit data width must match the instruction set");
    end

    function automatic logic is_rotate(input logic [INSN_W-1:0] w);
        return w[INSN_W-1:OPC_LSB] == OPC_ROT_LEFT ||
            w[INSN_W-1:OPC_LSB] == OPC_ROT_RIGHT;
    endfunction

    phase_t phase_ff, nxt_phase;
    logic [INSN_W-1:0] insn_ff;
    logic active_ff;
    logic [DW-1:0] opnd_ff, res_ff, acc_ff, wdata_ff;
    logic carry_ff, res_carry_ff, we_ff, rd_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DW-1:0] rot_data;
    logic rot_carry;

    wire take = I_INSN_VALID && is_rotate(I_INSN);
    wire op_left = insn_ff[INSN_W-1:OPC_LSB] == OPC_ROT_LEFT;
    wire to_reg = insn_ff[DEST_BIT];
    wire in_decode = phase_ff == PH_DECODE;
    wire in_read = phase_ff == PH_READ;
    wire in_proc = phase_ff == PH_PROCESS;
    wire in_write = phase_ff == PH_WRITE;

    rot_shift #(.WIDTH(DW)) u_shift (
        .i_data(opnd_ff),
        .i_carry(carry_ff),
        .i_left(op_left),
        .o_data(rot_data),
        .o_carry(rot_carry)
    );

    // phases always cycle so every instruction takes exactly four clocks
    always_comb begin
        case (phase_ff)
            PH_DECODE: nxt_phase = PH_READ;
            PH_READ: nxt_phase = PH_PROCESS;
            PH_PROCESS: nxt_phase = PH_WRITE;
            PH_WRITE: nxt_phase = PH_DECODE;
            default: nxt_phase = PH_DECODE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            phase_ff <= PH_DECODE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // instruction is sampled only in the decode phase
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            insn_ff <= '0;
            active_ff <= 1'b0;
        end else if (in_decode) begin
            insn_ff <= I_INSN;
            active_ff <= take;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            addr_ff <= '0;
            rd_ff <= 1'b0;
        end else begin
            rd_ff <= in_decode && take;
            if (in_decode && take) begin
                addr_ff <= I_INSN[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            opnd_ff <= '0;
        end else if (in_read && active_ff) begin
            opnd_ff <= I_RF_RDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            res_ff <= '0;
            res_carry_ff <= CARRY_RESET;
        end else if (in_proc && active_ff) begin
            res_ff <= rot_data;
            res_carry_ff <= rot_carry;
        end
    end

    // write phase: commit result and carry together
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            acc_ff <= ACC_RESET;
            carry_ff <= CARRY_RESET;
            we_ff <= 1'b0;
            wdata_ff <= '0;
        end else begin
            we_ff <= in_write && active_ff && to_reg;
            if (in_write && active_ff) begin
                carry_ff <= res_carry_ff;
                if (to_reg) begin
                    wdata_ff <= res_ff;
                end else begin
                    acc_ff <= res_ff;
                end
            end
        end
    end

    assign O_RF_ADDR = addr_ff;
    assign O_RF_RD = rd_ff;
    assign O_RF_WE = we_ff;
    assign O_RF_WDATA = wdata_ff;
    assign O_ACC = acc_ff;
    assign O_CARRY = carry_ff;
    assign O_BUSY = active_ff;

    // outputs are registered, so a result shows one edge after its phase
    chk_read_follows: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && take |=> O_RF_RD ##1 !O_RF_RD)
        else $error("read strobe not one cycle after decode");

    chk_reg_write: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && take && I_INSN[DEST_BIT] |=> ##2 !O_RF_WE ##1 O_RF_WE)
        else $error("register write missing after write phase");

    chk_acc_kept: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        O_RF_WE |-> $stable(O_ACC))
        else $error("accumulator changed on register write");

    chk_no_acc_write: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && take && !I_INSN[DEST_BIT] |=> ##3 !O_RF_WE)
        else $error("register written for accumulator destination");

    chk_left_carry: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_proc && active_ff && op_left |=>
        res_carry_ff == $past(opnd_ff[DW-1]) && res_ff[0] == $past(carry_ff))
        else $error("left rotate carry wrong");

    chk_right_carry: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_proc && active_ff && !op_left |=>
        res_carry_ff == $past(opnd_ff[0]) && res_ff[DW-1] == $past(carry_ff))
        else $error("right rotate carry wrong");

    chk_left_body: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_proc && active_ff && op_left |=>
        res_ff[DW-1:1] == $past(opnd_ff[DW-2:0]))
        else $error("left rotate moved data bits wrongly");

    chk_right_body: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_proc && active_ff && !op_left |=>
        res_ff[DW-2:0] == $past(opnd_ff[DW-1:1]))
        else $error("right rotate moved data bits wrongly");

    chk_carry_only_write: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        !(in_write && active_ff) |=> $stable(O_CARRY))
        else $error("carry changed outside write phase");

    chk_carry_commit: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_write && active_ff |=> O_CARRY == $past(res_carry_ff))
        else $error("carry not committed in write phase");

    chk_acc_result: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_write && active_ff && !to_reg |=> O_ACC == $past(res_ff))
        else $error("accumulator does not hold the rotated result");

    chk_wdata_result: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_write && active_ff && to_reg |=>
        O_RF_WE && O_RF_WDATA == $past(res_ff))
        else $error("register write data is not the rotated result");

    chk_addr_taken: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && take |=> O_RF_ADDR == $past(I_INSN[ADDR_W-1:0]))
        else $error("register address not taken from the instruction");

    chk_busy_span: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && take |=> O_BUSY [*4])
        else $error("busy dropped inside an instruction cycle");

    chk_refuse_quiet: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode && !take |=> !O_RF_RD ##3
        !O_RF_WE && $stable(O_ACC) && $stable(O_CARRY))
        else $error("ignored word changed outputs");

    chk_four_phase: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        in_decode |=> in_read ##1 in_proc ##1 in_write ##1 in_decode)
        else $error("instruction cycle not four phases");
endmodule
`default_nettype wire

/* rot_pkg.sv */
/*
 * constants for the rotate-through-carry execution unit.
 * assumes a 14-bit instruction word and 8-bit data path.
 */
package rot_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_W = 6;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam logic [OPC_W-1:0] OPC_ROT_LEFT = 6'h0D;
    localparam logic [OPC_W-1:0] OPC_ROT_RIGHT = 6'h0C;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_t;
endpackage

/* rot_shift.sv */
/*
 * combinational one-place rotate of a word through a carry bit.
 * assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
module rot_shift #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_carry,
    input wire logic i_left,
    output logic [WIDTH-1:0] o_data,
    output logic o_carry
);
    if (WIDTH < 2) begin : g_bad_width
        $error("rot_shift needs WIDTH of at least 2");
    end
    wire [WIDTH-1:0] left_data = {i_data[WIDTH-2:0], i_carry};
    wire [WIDTH-1:0] right_data = {i_carry, i_data[WIDTH-1:1]};
    assign o_data = i_left ? left_data : right_data;
    assign o_carry = i_left ? i_data[WIDTH-1] : i_data[0];
endmodule
`default_nettype wire

/* rot_rf_model.sv */
/* register file model facing the rotate unit.
   assumes reads are combinational while i_rd is high. */
`timescale 1ns/1ps
`default_nettype none
module rot_rf_model (
    input wire logic i_clk,
    input wire logic i_rd,
    input wire logic i_we,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:127];
    logic [7:0] last;
    initial begin
        last = 8'h00;
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h25 + 8'h5A);
    end
    always @(posedge i_clk) begin
        if (i_we) mem[i_addr] <= i_wdata;
        if (i_rd) last <= mem[i_addr];
    end
    // not read: drive the inverse so stale data cannot pass
    assign o_rdata = i_rd ? mem[i_addr] : ~last;
endmodule
`default_nettype wire

/* rot_unit_tb.sv */
/* self-checking bench for rot_unit.
   assumes rot_rf_model as register file and four-edge phases. */
`timescale 1ns/1ps
`default_nettype none
module rot_unit_tb;
    import rot_pkg::*;
    logic I_CLK, I_ARST_N, I_INSN_VALID, O_RF_RD, O_RF_WE, O_CARRY, O_BUSY;
    logic [13:0] I_INSN;
    logic [7:0] I_RF_RDATA, O_RF_WDATA, O_ACC, e_acc;
    logic [6:0] O_RF_ADDR;
    logic [7:0] mirror [0:127];
    logic e_c;
    int n_errors, checks;
    rot_unit dut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_INSN(I_INSN),
        .I_INSN_VALID(I_INSN_VALID), .I_RF_RDATA(I_RF_RDATA),
        .O_RF_ADDR(O_RF_ADDR), .O_RF_RD(O_RF_RD), .O_RF_WE(O_RF_WE),
        .O_RF_WDATA(O_RF_WDATA), .O_ACC(O_ACC), .O_CARRY(O_CARRY),
        .O_BUSY(O_BUSY));
    rot_rf_model u_rf (.i_clk(I_CLK), .i_rd(O_RF_RD), .i_we(O_RF_WE),
        .i_addr(O_RF_ADDR), .i_wdata(O_RF_WDATA), .o_rdata(I_RF_RDATA));
    task automatic chk(input string nm, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one instruction slot plus one idle slot, decode edges stay aligned
    task automatic exec(input logic [5:0] o, input logic d,
                        input logic [6:0] a, input logic v);
        logic tk;
        logic [7:0] op, res;
        tk = v && (o === OPC_ROT_LEFT || o === OPC_ROT_RIGHT);
        op = mirror[a];
        res = (o === OPC_ROT_LEFT) ? {op[6:0], e_c} : {e_c, op[7:1]};
        @(negedge I_CLK);
        I_INSN = {o, d, a};
        I_INSN_VALID = v;
        @(negedge I_CLK);
        chk("rd_busy", {6'h00, O_RF_RD, O_BUSY}, {6'h00, tk, tk});
        if (tk) chk("addr", {1'b0, O_RF_ADDR}, {1'b0, a});
        I_INSN_VALID = 1'b0;
        if (tk) begin
            e_c = (o === OPC_ROT_LEFT) ? op[7] : op[0];
            if (d) mirror[a] = res;
            else e_acc = res;
        end
        repeat (3) @(negedge I_CLK);
        chk("acc", O_ACC, e_acc);
        chk("carry", {7'h00, O_CARRY}, {7'h00, e_c});
        chk("we", {7'h00, O_RF_WE}, {7'h00, tk && d});
        if (tk && d) chk("wdata", O_RF_WDATA, res);
        @(negedge I_CLK);
        chk("we_end", {7'h00, O_RF_WE}, 8'h00);
        chk("reg", u_rf.mem[a], mirror[a]);
        repeat (3) @(posedge I_CLK);
    endtask
    task automatic t_rst();
        @(negedge I_CLK);
        I_ARST_N = 1'b0;
        I_INSN_VALID = 1'b0;
        repeat (16) @(negedge I_CLK);
        chk("acc_rst", O_ACC, ACC_RESET);
        chk("carry_rst", {7'h00, O_CARRY}, {7'h00, CARRY_RESET});
        chk("strobe_rst", {5'h00, O_RF_RD, O_RF_WE, O_BUSY}, 8'h00);
        e_acc = ACC_RESET;
        e_c = CARRY_RESET;
        I_ARST_N = 1'b1;
        repeat (4) @(posedge I_CLK);
        $display("reset test done");
    endtask
    task automatic t_left();
        exec(OPC_ROT_LEFT, 1'b0, 7'h00, 1'b1);
        exec(OPC_ROT_LEFT, 1'b1, 7'h7F, 1'b1);
        exec(OPC_ROT_LEFT, 1'b0, 7'h7F, 1'b1);
        exec(OPC_ROT_LEFT, 1'b1, 7'h05, 1'b1);
        $display("left test done");
    endtask
    task automatic t_right();
        exec(OPC_ROT_RIGHT, 1'b0, 7'h03, 1'b1);
        exec(OPC_ROT_RIGHT, 1'b1, 7'h7F, 1'b1);
        exec(OPC_ROT_RIGHT, 1'b1, 7'h00, 1'b1);
        exec(OPC_ROT_RIGHT, 1'b0, 7'h44, 1'b1);
        $display("right test done");
    endtask
    task automatic t_refuse();
        exec(OPC_ROT_LEFT, 1'b1, 7'h09, 1'b0);
        exec(6'h0E, 1'b1, 7'h09, 1'b1);
        exec(6'h2D, 1'b0, 7'h09, 1'b1);
        exec(6'h1C, 1'b1, 7'h09, 1'b1);
        $display("refuse test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        I_CLK = 1'b0;
        forever #50 I_CLK = ~I_CLK;
    end
    initial begin
        I_ARST_N = 1'b0;
        I_INSN = 14'h0000;
        I_INSN_VALID = 1'b0;
        n_errors = 0;
        checks = 0;
        for (int i = 0; i < 128; i++) mirror[i] = 8'(i * 8'h25 + 8'h5A);
        t_rst();
        t_left();
        t_right();
        t_refuse();
        t_rst();
        t_right();
        end_of_test();
    end
endmodule
`default_nettype wire
